//--- rtl/tasm_map.vh
// register offsets, field positions and constants of the temperature alarm block
`ifndef TASM_MAP_VH
`define TASM_MAP_VH
`define TASM_ADDR_CFG 8'h41
`define TASM_ADDR_AMASK 8'h42
`define TASM_ADDR_OMASK 8'h43
`define TASM_ADDR_HSTAT 8'h44
`define TASM_ADDR_OSTAT 8'h45
`define TASM_ADDR_FSTAT 8'h46
`define TASM_ADDR_LSTAT 8'h47
`define TASM_CFG_STANDBY 7
`define TASM_CFG_SOFTRST 6
`define TASM_CFG_TMO_DIS 5
`define TASM_CFG_EXTENDED_RANGE_ENABLE 1
`define TASM_CFG_WMASK 8'hE2
`define TASM_CFG_SRST_MASK 8'h40
`define TASM_CH_LOCAL 3'h0
`define TASM_CH_TOP 3'h7
`define TASM_RST_BYTE 8'h00
`define TASM_FAULT_TEMP 8'hFF
`define TASM_HYST 8'h04
`define TASM_EXT_OFFSET 8'h40
`endif

//--- rtl/tasm_alarm.v
// configuration, channel masks, status flags and alarm outputs of an 8-channel temp monitor
`timescale 1ns/10ps
`include "tasm_map.vh"
module tasm_alarm (
   // clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // register access from the serial engine
   input wire i_wr_stb,
   input wire i_rd_stb,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   // alert response completed by the host
   input wire i_ara_done,
   // conversion result, one channel per strobe
   input wire i_conv_done,
   input wire [2:0] i_conv_ch,
   input wire [7:0] i_conv_temp,
   input wire i_conv_open,
   input wire i_conv_short,
   // limits for the converted channel, raw codes
   input wire [7:0] i_lim_high,
   input wire [7:0] i_lim_low,
   input wire [7:0] i_lim_over,
   // over-temperature limit rewrite for one channel
   input wire i_olim_wr,
   input wire [2:0] i_olim_ch,
   input wire [7:0] i_olim_val,
   input wire [7:0] i_olim_cur_temp,
   // configuration seen by sequencer and bus engine
   output wire o_conv_run,
   output wire o_bus_tmo_en,
   output wire o_ext_range,
   output reg [7:0] o_stored_temp,
   // open-drain alarm pins, enable high drives low
   output wire o_alert_n_out,
   output wire o_alert_n_oe,
   output wire o_overt_n_out,
   output wire o_overt_n_oe
);

// registers
reg [7:0] cfg_reg;
reg [7:0] cfg_next;
reg [7:0] amask_reg;
reg [7:0] amask_next;
reg [7:0] omask_reg;
reg [7:0] omask_next;
// status flags, set by conversions
reg [7:0] hstat_reg;
reg [7:0] hstat_next;
reg [7:0] ostat_reg;
reg [7:0] ostat_next;
reg [7:0] fstat_reg;
reg [7:0] fstat_next;
reg [7:0] lstat_reg;
reg [7:0] lstat_next;
// alert pin latch, cleared by reads and responses
reg alert_latch_reg;
reg alert_latch_next;
// next values of the data outputs
reg [7:0] rdata_next;
reg [7:0] stored_next;

// per-channel event bits in status-register order
wire [7:0] sel_ch;
wire [7:0] hi_evt;
wire [7:0] lo_evt;
wire [7:0] ov_evt;
wire [7:0] ov_clr;
wire [7:0] ov_lim_clr;
wire [7:0] flt_evt;
// conversion qualifiers and reset strobe
wire diode_fault;
wire soft_rst;
wire any_alert;
// register write and read decodes
wire cfg_wr;
wire amask_wr;
wire omask_wr;
wire hstat_rd;
wire lstat_rd;
wire fstat_rd;

// open or shorted diode voids the comparisons
assign diode_fault = i_conv_open | i_conv_short;
// soft reset strobe from configuration write
assign soft_rst = i_wr_stb && (i_addr == `TASM_ADDR_CFG) && i_wdata[`TASM_CFG_SOFTRST];

// register decodes shared by the update logic
assign cfg_wr = i_wr_stb && (i_addr == `TASM_ADDR_CFG);
assign amask_wr = i_wr_stb && (i_addr == `TASM_ADDR_AMASK);
assign omask_wr = i_wr_stb && (i_addr == `TASM_ADDR_OMASK);
// read side effects only on a completed host read
assign hstat_rd = i_rd_stb && (i_addr == `TASM_ADDR_HSTAT);
assign lstat_rd = i_rd_stb && (i_addr == `TASM_ADDR_LSTAT);
assign fstat_rd = i_rd_stb && (i_addr == `TASM_ADDR_FSTAT);

// channel code: 0 local, 1..7 remote; map into alert-order and overtemp-order bits
genvar g;
generate
   for (g = 0; g < 8; g = g + 1) begin : g_ch
      // alert order: bit7 remote 7, bit6 local, bits5..0 remote 6..1
      localparam [2:0] ACH = (g == 7) ? `TASM_CH_TOP : (g == 6) ? `TASM_CH_LOCAL : g + 1;
      // overtemp order: bit7 local, bits6..0 remote 7..1
      localparam [2:0] OCH = (g == 7) ? `TASM_CH_LOCAL : g + 1;
      // strobes for this bit's channel in either order
      wire a_hit;
      wire o_hit;
      assign a_hit = i_conv_done && (i_conv_ch == ACH);
      assign o_hit = i_conv_done && (i_conv_ch == OCH);
      assign sel_ch[g] = a_hit;
      // faulted channel compares nothing, so an open diode raises no alarm
      assign hi_evt[g] = sel_ch[g] && !diode_fault && (i_conv_temp > i_lim_high);
      assign lo_evt[g] = sel_ch[g] && !diode_fault && (i_conv_temp < i_lim_low);
      assign ov_evt[g] = o_hit && !diode_fault && (i_conv_temp > i_lim_over);
      // clear below limit minus hysteresis, guarded against wrap
      assign ov_clr[g] = o_hit && !diode_fault && (i_lim_over >= `TASM_HYST) &&
         (i_conv_temp < (i_lim_over - `TASM_HYST));
      // limit raised to at least hysteresis above present temperature
      assign ov_lim_clr[g] = i_olim_wr && (i_olim_ch == OCH) && (i_olim_val >= `TASM_HYST) &&
         (i_olim_cur_temp <= (i_olim_val - `TASM_HYST));
      // diode-fault register: bits6..0 remote 7..1, bit7 reserved
      if (g < 7) begin : g_flt
         assign flt_evt[g] = i_conv_done && (i_conv_ch == OCH) && diode_fault;
      end else begin : g_nflt
         assign flt_evt[g] = 1'b0;
      end
   end
endgenerate

// configuration and masks
always @* begin
   cfg_next = cfg_reg;
   amask_next = amask_reg;
   omask_next = omask_reg;
   if (cfg_wr) begin
      // reserved bits kept zero; soft-reset bit never stored so it reads back cleared
      cfg_next = i_wdata & `TASM_CFG_WMASK & ~`TASM_CFG_SRST_MASK;
   end
   // alert mask, one bit per channel
   if (amask_wr) begin
      amask_next = i_wdata;
   end
   // overtemp mask, one bit per channel
   if (omask_wr) begin
      omask_next = i_wdata;
   end
end

// status flags: set wins over any clear in the same cycle
always @* begin
   hstat_next = hstat_reg;
   lstat_next = lstat_reg;
   fstat_next = fstat_reg;
   ostat_next = ostat_reg;
   alert_latch_next = alert_latch_reg;
   // high status read clears flags and the pin
   if (hstat_rd) begin
      hstat_next = `TASM_RST_BYTE;
      alert_latch_next = 1'b0;
   end
   // low status read behaves the same
   if (lstat_rd) begin
      lstat_next = `TASM_RST_BYTE;
      alert_latch_next = 1'b0;
   end
   // fault read clears diode flags only
   if (fstat_rd) begin
      fstat_next = `TASM_RST_BYTE;
   end
   // completed alert response drops the pin
   if (i_ara_done) begin
      alert_latch_next = 1'b0;
   end
   // overtemp flags ignore reads, clear by hysteresis or limit change
   ostat_next = (ostat_reg & ~(ov_clr | ov_lim_clr)) | ov_evt;
   // alert flags set on fresh events
   hstat_next = hstat_next | hi_evt;
   lstat_next = lstat_next | lo_evt;
   fstat_next = fstat_next | flt_evt;
   // masks do not touch flags; latch re-arms on any conversion while an unmasked high or low flag is set
   if (|((hstat_next | lstat_next) & ~amask_reg) && i_conv_done) begin
      alert_latch_next = 1'b1;
   end
   if (|((hi_evt | lo_evt) & ~amask_reg)) begin
      alert_latch_next = 1'b1;
   end
end

// read mux
always @* begin
   // status reads return flags before clearing
   case (i_addr)
      `TASM_ADDR_CFG: rdata_next = cfg_reg;
      `TASM_ADDR_AMASK: rdata_next = amask_reg;
      `TASM_ADDR_OMASK: rdata_next = omask_reg;
      `TASM_ADDR_HSTAT: rdata_next = hstat_reg;
      `TASM_ADDR_OSTAT: rdata_next = ostat_reg;
      `TASM_ADDR_FSTAT: rdata_next = fstat_reg;
      `TASM_ADDR_LSTAT: rdata_next = lstat_reg;
      default: rdata_next = `TASM_RST_BYTE;
   endcase
end

// stored temperature, all ones on a diode fault
always @* begin
   // holds last result between conversions
   stored_next = o_stored_temp;
   if (i_conv_done) begin
      stored_next = diode_fault ? `TASM_FAULT_TEMP : i_conv_temp;
   end
end

// configuration register; soft reset acts like power-on reset
always @(posedge i_clk) begin
   if (!i_rst_n || soft_rst) begin
      cfg_reg <= `TASM_RST_BYTE;
   end else begin
      cfg_reg <= cfg_next;
   end
end

// alert mask register
always @(posedge i_clk) begin
   if (!i_rst_n || soft_rst) begin
      amask_reg <= `TASM_RST_BYTE;
   end else begin
      amask_reg <= amask_next;
   end
end

// overtemp mask register
always @(posedge i_clk) begin
   if (!i_rst_n || soft_rst) begin
      omask_reg <= `TASM_RST_BYTE;
   end else begin
      omask_reg <= omask_next;
   end
end

// high-alert status flags
always @(posedge i_clk) begin
   if (!i_rst_n || soft_rst) begin
      hstat_reg <= `TASM_RST_BYTE;
   end else begin
      hstat_reg <= hstat_next;
   end
end

// overtemp status flags
always @(posedge i_clk) begin
   if (!i_rst_n || soft_rst) begin
      ostat_reg <= `TASM_RST_BYTE;
   end else begin
      ostat_reg <= ostat_next;
   end
end

// diode fault flags
always @(posedge i_clk) begin
   if (!i_rst_n || soft_rst) begin
      fstat_reg <= `TASM_RST_BYTE;
   end else begin
      fstat_reg <= fstat_next;
   end
end

// low-alert status flags
always @(posedge i_clk) begin
   if (!i_rst_n || soft_rst) begin
      lstat_reg <= `TASM_RST_BYTE;
   end else begin
      lstat_reg <= lstat_next;
   end
end

// alert pin latch
always @(posedge i_clk) begin
   if (!i_rst_n || soft_rst) begin
      alert_latch_reg <= 1'b0;
   end else begin
      alert_latch_reg <= alert_latch_next;
   end
end

// stored temperature output
always @(posedge i_clk) begin
   if (!i_rst_n || soft_rst) begin
      o_stored_temp <= `TASM_RST_BYTE;
   end else begin
      o_stored_temp <= stored_next;
   end
end

// registered read data
always @(posedge i_clk) begin
   if (!i_rst_n || soft_rst) begin
      o_rdata <= `TASM_RST_BYTE;
   end else begin
      o_rdata <= rdata_next;
   end
end

// configuration outputs
assign o_conv_run = ~cfg_reg[`TASM_CFG_STANDBY];
assign o_bus_tmo_en = ~cfg_reg[`TASM_CFG_TMO_DIS];
assign o_ext_range = cfg_reg[`TASM_CFG_EXTENDED_RANGE_ENABLE];

// alarm pins, pulled low while asserted
assign any_alert = alert_latch_reg;
assign o_alert_n_out = 1'b0;
assign o_alert_n_oe = any_alert;
// overtemp pin from flags, masks gate it only
assign o_overt_n_out = 1'b0;
assign o_overt_n_oe = |(ostat_reg & ~omask_reg);

endmodule

//--- tb/tasm_checker.sv
// port assertions of the temperature alarm block
`timescale 1ns/10ps
module tasm_checker (
   // watched ports
   input wire i_clk, i_rst_n, i_wr_stb, i_rd_stb, i_ara_done, i_conv_done,
   input wire i_conv_open, i_olim_wr, o_conv_run, o_bus_tmo_en, o_ext_range,
   input wire o_alert_n_oe, o_overt_n_oe,
   input wire [7:0] i_addr, i_wdata, o_rdata, o_stored_temp
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // config write that is not a soft reset
   wire cfg_wr = i_wr_stb && i_addr == 8'h41 && !i_wdata[6];
   property p_stop; cfg_wr |=> o_conv_run == !$past(i_wdata[7]); endproperty
   a_stop: assert property (p_stop) else $error("run level wrong");
   property p_tmo; cfg_wr |=> o_bus_tmo_en == !$past(i_wdata[5]); endproperty
   a_tmo: assert property (p_tmo) else $error("timeout level wrong");
   property p_ext; cfg_wr |=> o_ext_range == $past(i_wdata[1]); endproperty
   a_ext: assert property (p_ext) else $error("range level wrong");
   property p_srst; i_wr_stb && i_addr == 8'h41 && i_wdata[6] |=> o_conv_run
      && o_bus_tmo_en && !o_ext_range && !o_alert_n_oe && !o_overt_n_oe; endproperty
   a_srst: assert property (p_srst) else $error("soft reset incomplete");
   property p_rdclr; i_rd_stb && i_addr == 8'h44 && !i_conv_done |=> !o_alert_n_oe;
   endproperty
   a_rdclr: assert property (p_rdclr) else $error("read kept alert");
   property p_ara; i_ara_done && !i_conv_done |=> !o_alert_n_oe; endproperty
   a_ara: assert property (p_ara) else $error("response kept alert");
   property p_rise; $rose(o_alert_n_oe) |-> $past(i_conv_done); endproperty
   a_rise: assert property (p_rise) else $error("alert without conversion");
   property p_hyst; $fell(o_overt_n_oe) |-> $past(i_conv_done || i_olim_wr || i_wr_stb);
   endproperty
   a_hyst: assert property (p_hyst) else $error("overtemp dropped early");
   property p_fault; i_conv_done && i_conv_open |=> o_stored_temp == 8'hFF; endproperty
   a_fault: assert property (p_fault) else $error("fault temp wrong");
   // main scenarios
   c_cfg: cover property (cfg_wr);
   c_ovt: cover property ($rose(o_overt_n_oe));
   c_ara: cover property (i_ara_done && o_alert_n_oe);
endmodule
bind tasm_alarm tasm_checker u_chk (.*);

//--- tb/tasm_host.sv
// host master model issuing register accesses
`timescale 1ns/10ps
module tasm_host (
   input wire i_clk,
   output reg o_wr, o_rd, o_ara,
   output reg [7:0] o_addr, o_wdata,
   input wire [7:0] i_rdata
);
   initial {o_wr, o_rd, o_ara, o_addr, o_wdata} = 19'h0;
   // write byte, value driven unchanged for one cycle
   task wr(input [7:0] a, input [7:0] v);
      begin
         @(negedge i_clk); o_addr = a; o_wdata = v; o_wr = 1;
         @(negedge i_clk); o_wr = 0;
      end
   endtask
   // read byte, data taken one cycle on
   task rd(input [7:0] a, output [7:0] v);
      begin
         @(negedge i_clk); o_addr = a; o_rd = 1;
         @(negedge i_clk); o_rd = 0; v = i_rdata;
      end
   endtask
   // alert response receive-byte completed
   task ara;
      begin
         @(negedge i_clk); o_ara = 1;
         @(negedge i_clk); o_ara = 0;
      end
   endtask
endmodule

//--- tb/testbench.sv
// self-checking bench of the temperature alarm block
`timescale 1ns/10ps
module testbench;
   reg clk = 0, rst_n = 0, cd = 0, co = 0, ow = 0, cs = 0;
   reg [2:0] cc = 0, oc = 0;
   reg [7:0] ct = 0, ov = 0, oct = 0, d, i;
   wire wr, rd, ara, ao, aoe, oo, ooe, run, tmo, ext;
   wire [7:0] a, wd, rdat, st;
   integer fails = 0, comparisons = 0;
   tasm_host h (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_ara(ara), .o_addr(a),
      .o_wdata(wd), .i_rdata(rdat));
   tasm_alarm DUT (.i_clk(clk), .i_rst_n(rst_n), .i_wr_stb(wr), .i_rd_stb(rd),
      .i_addr(a), .i_wdata(wd), .o_rdata(rdat), .i_ara_done(ara), .i_conv_done(cd),
      .i_conv_ch(cc), .i_conv_temp(ct), .i_conv_open(co), .i_conv_short(cs),
      .i_lim_high(8'h70), .i_lim_low(8'h20), .i_lim_over(8'h80), .i_olim_wr(ow),
      .i_olim_ch(oc), .i_olim_val(ov), .i_olim_cur_temp(oct), .o_conv_run(run),
      .o_bus_tmo_en(tmo), .o_ext_range(ext), .o_stored_temp(st), .o_alert_n_out(ao),
      .o_alert_n_oe(aoe), .o_overt_n_out(oo), .o_overt_n_oe(ooe));
   initial forever #10 clk = ~clk;
   // byte and pin comparisons
   task chk(input [7:0] g, input [7:0] e);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            fails = fails + 1;
            $display("BAD %0t got %h want %h", $time, g, e);
         end
      end
   endtask
   task pins(input [1:0] e);
      chk({4'h0, ao, oo, aoe, ooe}, {6'h0, e});
   endtask
   task rc(input [7:0] ad, input [7:0] e);
      begin h.rd(ad, d); chk(d, e); end
   endtask
   // one conversion result
   task cv(input [2:0] c, input [7:0] t);
      begin
         @(negedge clk); cc = c; ct = t; cd = 1;
         @(negedge clk); cd = 0;
      end
   endtask
   task print_verdict;
      begin
         if (fails == 0 && comparisons > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin #20000; fails = fails + 1; print_verdict; end
   // main sequence
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1;
      for (i = 8'h41; i < 8'h49; i = i + 1) rc(i, 8'h00);
      chk({5'h0, run, tmo, ext}, 8'h06);
      h.wr(8'h41, 8'hA2); rc(8'h41, 8'hA2);
      chk({5'h0, run, tmo, ext}, 8'h01);
      h.wr(8'h42, 8'h5A); h.wr(8'h41, 8'h40); rc(8'h41, 8'h00);
      rc(8'h42, 8'h00); chk({5'h0, run, tmo, ext}, 8'h06);
      h.wr(8'h42, 8'h40); cv(0, 8'h80); pins(2'b00);
      cv(1, 8'h80); pins(2'b10);
      rc(8'h44, 8'h41); pins(2'b00);
      rc(8'h44, 8'h00); cv(1, 8'h80); pins(2'b10);
      h.ara; pins(2'b00); rc(8'h44, 8'h01);
      h.wr(8'h42, 8'hFF); h.wr(8'h43, 8'h80); cv(0, 8'h90); pins(2'b00);
      cv(7, 8'h90); pins(2'b01); rc(8'h45, 8'hC0);
      rc(8'h45, 8'hC0); cv(7, 8'h7D); rc(8'h45, 8'hC0);
      cv(7, 8'h7B); rc(8'h45, 8'h80); pins(2'b00);
      cv(7, 8'h90); pins(2'b01);
      @(negedge clk); oc = 7; ov = 8'h94; oct = 8'h90; ow = 1;
      @(negedge clk); ow = 0;
      pins(2'b00); rc(8'h45, 8'h80);
      h.rd(8'h44, d); h.rd(8'h47, d); h.wr(8'h42, 8'h00);
      cv(2, 8'h10); pins(2'b10); rc(8'h47, 8'h02);
      co = 1; cv(3, 8'h90); co = 0;
      chk(st, 8'hFF); pins(2'b00); rc(8'h46, 8'h04);
      cs = 1; cv(4, 8'h10); cs = 0;
      chk(st, 8'hFF); pins(2'b00); rc(8'h46, 8'h08);
      @(negedge clk); rst_n = 0; @(negedge clk); rst_n = 1;
      rc(8'h45, 8'h00); rc(8'h41, 8'h00);
      print_verdict;
   end
endmodule
